// [logic/cpid_pkg.sv]
/*
  Constants, register map and carrier types for the command pulse input decoder.
  Assumes an APB master with 32-bit data and a 100 MHz core clock.
*/
// Behaviour
// - three pulse formats: quadrature, fwd/rev, pulse+sign
// - fast differential path counts up to 4 Mpps
// - isolated path counts up to 500 kpps
// - path select: 0 isolated, 1 fast, 2 slow-isolated
// - direction bit sets positive counting sense
// - method setting 0..3 picks format and edges
// - inhibit enabled and input open blocks counting
// - flag one pulse or fewer per control cycle
// - deviation clear input zeroes deviation counter
package cpid_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CPID_OFS_CTRL = 8'h00;
  localparam logic [7:0] CPID_OFS_STATUS = 8'h04;
  localparam logic [7:0] CPID_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] CPID_OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] CPID_OFS_CMD_POS = 8'h10;
  localparam logic [7:0] CPID_OFS_DEV_CNT = 8'h14;
  localparam logic [7:0] CPID_OFS_FB_STEP = 8'h18;
  // ---------------------------------------------------------------
  // control field positions and reset values
  // ---------------------------------------------------------------
  localparam int CPID_CTRL_PATH_LSB = 0;
  localparam int CPID_CTRL_DIR_BIT = 2;
  localparam int CPID_CTRL_METH_LSB = 3;
  localparam int CPID_CTRL_INHEN_BIT = 5;
  localparam logic [31:0] CPID_CTRL_RST = 32'h0000_0000;
  // irq bits: 0 low frequency, 1 never set, 2 pulse blocked by inhibit, 3 clear seen
  localparam int CPID_IRQ_W = 4;
  localparam logic [3:0] CPID_IRQ_RST = 4'h0;
  // ---------------------------------------------------------------
  // path select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] CPID_PATH_ISO = 2'h0;
  localparam logic [1:0] CPID_PATH_FAST = 2'h1;
  localparam logic [1:0] CPID_PATH_ISO_SLOW = 2'h2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CPID_CLK_MHZ = 100;
  localparam int CPID_CTRL_CYCLE_NS = 62500;  // control cycle period
  localparam int CPID_CTRL_CYCLE_CLK = CPID_CTRL_CYCLE_NS * CPID_CLK_MHZ / 1000;
  localparam int CPID_FAST_KPPS = 4000;
  localparam int CPID_ISO_KPPS = 500;
  localparam int CPID_ISO_SLOW_KPPS = 250;
  // glitch filter lengths: a pulse must stay stable for this many clocks;
  // shorter than half the period at the fastest legal rate of the path
  localparam int CPID_FILT_FAST_CLK = 2;
  localparam int CPID_FILT_ISO_CLK = CPID_CLK_MHZ * 1000 / CPID_ISO_KPPS / 4;
  localparam int CPID_FILT_SLOW_CLK = CPID_CLK_MHZ * 1000 / CPID_ISO_SLOW_KPPS / 4;
  localparam logic [31:0] CPID_CNT_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pulse;
    logic sign;
  } cpid_pair_t;

  typedef struct packed {
    logic [1:0] path;
    logic dir;
    logic [1:0] method;
    logic inhEn;
  } cpid_cfg_t;

  typedef enum logic [2:0] {
    CPID_APB_IDLE = 3'b001,
    CPID_APB_SETUP = 3'b010,
    CPID_APB_ACCESS = 3'b100
  } cpid_apb_t;
endpackage : cpid_pkg

// [logic/cpid_decoder.sv]
/*
  Command pulse input decoder with APB register slave and interrupt.
  Assumes pin inputs already synchronous-capable single-ended levels
  (differential pairs resolved as pos minus neg) and an APB master.
*/
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module cpid_decoder
  import cpid_pkg::*;
#(
  parameter int CTRL_CYCLE_CLK = CPID_CTRL_CYCLE_CLK,
  parameter int CNT_W = 32
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fast_pulse_pos,
  input wire logic fast_pulse_neg,
  input wire logic fast_sign_pos,
  input wire logic fast_sign_neg,
  input wire logic iso_pulse_pos,
  input wire logic iso_pulse_neg,
  input wire logic iso_sign_pos,
  input wire logic iso_sign_neg,
  input wire logic pulse_inhibit_in,
  input wire logic deviation_clear_in,
  output logic [CNT_W-1:0] cmdStep,
  output logic cmdStepValid,
  output logic lowFreq,
  output logic irq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  cpid_cfg_t cfg_ff;
  logic [3:0] irqStat_ff, irqMask_ff;
  logic [CNT_W-1:0] cmdPos_ff, devCnt_ff, fbStep_ff, cycAcc_ff, cmdStep_ff, cycTot;
  logic [31:0] cycTmr_ff, prdata_ff;
  logic [1:0] syncA_ff, syncB_ff, syncInh_ff, syncClr_ff;
  logic a_ff, b_ff, aPrev_ff, bPrev_ff;
  logic [15:0] filtA_ff, filtB_ff, filtLen;
  logic pready_ff, pslverr_ff, lowFreq_ff, irq_ff, cmdStepValid_ff;
  cpid_apb_t apbState_ff, nxt_apbState;
  logic rawA, rawB, inhibitNow, tick, accept, wrEn, rdEn, lowNow;
  logic [1:0] stepDir;
  logic [3:0] irqEvt;

  // differential/isolated pair resolved to one level
  function automatic logic pairLevel(input logic p, input logic n);
    pairLevel = p & ~n;
  endfunction : pairLevel
  // signed one-step value for an increment code: 01 is +1, 11 is -1
  function automatic logic [CNT_W-1:0] stepVal(input logic [1:0] s);
    stepVal = (s == 2'b11) ? {CNT_W{1'b1}} : {{(CNT_W-1){1'b0}}, s == 2'b01};
  endfunction : stepVal

  // ---------------------------------------------------------------
  // input path select and synchronisers
  // ---------------------------------------------------------------
  // path mux and filter
  always_comb
  begin
    if (cfg_ff.path == CPID_PATH_FAST)
    begin
      rawA = pairLevel(fast_pulse_pos, fast_pulse_neg);
      rawB = pairLevel(fast_sign_pos, fast_sign_neg);
      filtLen = 16'(CPID_FILT_FAST_CLK);
    end
    else
    begin
      rawA = pairLevel(iso_pulse_pos, iso_pulse_neg);
      rawB = pairLevel(iso_sign_pos, iso_sign_neg);
      // slow option filters harder, capping usable rate lower
      filtLen = (cfg_ff.path == CPID_PATH_ISO_SLOW) ? 16'(CPID_FILT_SLOW_CLK)
                                                     : 16'(CPID_FILT_ISO_CLK);
    end
  end
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA_ff <= 2'h0;
      syncB_ff <= 2'h0;
      syncInh_ff <= 2'h0;
      syncClr_ff <= 2'h0;
    end
    else
    begin
      syncA_ff <= {syncA_ff[0], rawA};
      syncB_ff <= {syncB_ff[0], rawB};
      syncInh_ff <= {syncInh_ff[0], pulse_inhibit_in};
      syncClr_ff <= {syncClr_ff[0], deviation_clear_in};
    end
  end

  // stability filter; fast path needs only 2 clocks at 4 Mpps
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filtA_ff <= 16'h0000;
      filtB_ff <= 16'h0000;
      a_ff <= 1'b0;
      b_ff <= 1'b0;
      aPrev_ff <= 1'b0;
      bPrev_ff <= 1'b0;
    end
    else
    begin
      aPrev_ff <= a_ff;
      bPrev_ff <= b_ff;
      if (syncA_ff[1] == a_ff)
        filtA_ff <= 16'h0000;
      else if (filtA_ff + 16'h0001 >= filtLen)
      begin
        a_ff <= syncA_ff[1];
        filtA_ff <= 16'h0000;
      end
      else
        filtA_ff <= filtA_ff + 16'h0001;
      if (syncB_ff[1] == b_ff)
        filtB_ff <= 16'h0000;
      else if (filtB_ff + 16'h0001 >= filtLen)
      begin
        b_ff <= syncB_ff[1];
        filtB_ff <= 16'h0000;
      end
      else
        filtB_ff <= filtB_ff + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // format decode
  // ---------------------------------------------------------------
  // format select; method 0/2 quadrature, 1 fwd/rev, 3 pulse+sign
  always_comb
  begin
    stepDir = 2'b00;
    case (cfg_ff.method)
      2'h0, 2'h2:
      begin
        // every edge of both phases, sense from leading phase
        if (a_ff != aPrev_ff)
          stepDir = (a_ff != b_ff) ? 2'b01 : 2'b11;
        else if (b_ff != bPrev_ff)
          stepDir = (a_ff == b_ff) ? 2'b01 : 2'b11;
      end
      2'h1:
      begin
        // rising edge on pulse line forward, on sign line reverse
        if (a_ff && !aPrev_ff)
          stepDir = 2'b01;
        else if (b_ff && !bPrev_ff)
          stepDir = 2'b11;
      end
      default:
      begin
        // pulse+sign: count rising pulse edge, sign high is reverse
        if (a_ff && !aPrev_ff)
          stepDir = b_ff ? 2'b11 : 2'b01;
      end
    endcase
    // direction setting flips the counted sense
    if (cfg_ff.dir && stepDir != 2'b00)
      stepDir = {~stepDir[1], 1'b1};
  end

  // inhibit enabled (setting 0) with input open blocks pulses
  assign inhibitNow = !cfg_ff.inhEn && !syncInh_ff[1];
  assign tick = (cycTmr_ff == 32'(CTRL_CYCLE_CLK - 1));
  // one total per cycle feeds both the step and its flag, so they never disagree
  assign cycTot = cycAcc_ff + (inhibitNow ? '0 : stepVal(stepDir));
  assign lowNow = ($signed(cycTot) <= 1) && ($signed(cycTot) >= -1);
  // ---------------------------------------------------------------
  // position counts
  // ---------------------------------------------------------------
  // clear zeroes deviation; commanded position keeps counting
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmdPos_ff <= CNT_W'(CPID_CNT_RST);
      devCnt_ff <= CNT_W'(CPID_CNT_RST);
    end
    else
    begin
      if (!inhibitNow)
        cmdPos_ff <= cmdPos_ff + stepVal(stepDir);
      if (syncClr_ff[1])
        devCnt_ff <= '0;
      else if (inhibitNow)
        devCnt_ff <= devCnt_ff - fbStep_ff;
      else
        devCnt_ff <= devCnt_ff + stepVal(stepDir) - fbStep_ff;
    end
  end
  // per control cycle accumulation and low frequency flag
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cycTmr_ff <= 32'h0000_0000;
      cycAcc_ff <= '0;
      cmdStep_ff <= '0;
      cmdStepValid_ff <= 1'b0;
      lowFreq_ff <= 1'b0;
    end
    else
    begin
      cycTmr_ff <= tick ? 32'h0000_0000 : cycTmr_ff + 32'h0000_0001;
      cmdStepValid_ff <= tick;
      if (tick)
      begin
        cmdStep_ff <= cycTot;
        cycAcc_ff <= '0;
        // one pulse or fewer this cycle, either sense
        lowFreq_ff <= lowNow;
      end
      else if (!inhibitNow)
        cycAcc_ff <= cycAcc_ff + stepVal(stepDir);
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  assign irqEvt = {syncClr_ff[1], inhibitNow && stepDir != 2'b00, 1'b0, tick && lowNow};
  // event set wins over write-one-to-clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqStat_ff <= CPID_IRQ_RST;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (wrEn && paddr == CPID_OFS_IRQ_STAT)
        irqStat_ff <= (irqStat_ff & ~pwdata[3:0]) | irqEvt;
      else
        irqStat_ff <= irqStat_ff | irqEvt;
      irq_ff <= |(irqStat_ff & irqMask_ff);
    end
  end

  // ---------------------------------------------------------------
  // apb slave: one wait state, reads registered
  // ---------------------------------------------------------------
  always_comb
  begin
    case (apbState_ff)
      CPID_APB_IDLE: nxt_apbState = (psel && !penable) ? CPID_APB_SETUP : CPID_APB_IDLE;
      CPID_APB_SETUP: nxt_apbState = CPID_APB_ACCESS;
      CPID_APB_ACCESS: nxt_apbState = CPID_APB_IDLE;
      default: nxt_apbState = CPID_APB_IDLE;
    endcase
  end
  // request taken at the setup edge; a write lands only on the edge that sees pready
  assign accept = (apbState_ff == CPID_APB_SETUP) && psel && penable;
  assign wrEn = (apbState_ff == CPID_APB_ACCESS) && psel && penable && pwrite;
  assign rdEn = accept && !pwrite;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      apbState_ff <= CPID_APB_IDLE;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      apbState_ff <= nxt_apbState;
      pready_ff <= accept;
      pslverr_ff <= 1'b0;
      if (rdEn)
      begin
        case (paddr)
          CPID_OFS_CTRL: prdata_ff <= {26'h0, cfg_ff.inhEn, cfg_ff.method,
                                       cfg_ff.dir, cfg_ff.path};
          CPID_OFS_STATUS: prdata_ff <= {29'h0, syncInh_ff[1], inhibitNow, lowFreq_ff};
          CPID_OFS_IRQ_STAT: prdata_ff <= {28'h0, irqStat_ff};
          CPID_OFS_IRQ_MASK: prdata_ff <= {28'h0, irqMask_ff};
          CPID_OFS_CMD_POS: prdata_ff <= 32'(cmdPos_ff);
          CPID_OFS_DEV_CNT: prdata_ff <= 32'(devCnt_ff);
          CPID_OFS_FB_STEP: prdata_ff <= 32'(fbStep_ff);
          default:
          begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b1;
          end
        endcase
      end
      else if (accept && pwrite)
        pslverr_ff <= !(paddr == CPID_OFS_CTRL || paddr == CPID_OFS_IRQ_STAT ||
                        paddr == CPID_OFS_IRQ_MASK || paddr == CPID_OFS_FB_STEP);
    end
  end
  // writable configuration
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_ff <= cpid_cfg_t'(6'(CPID_CTRL_RST));
      irqMask_ff <= CPID_IRQ_RST;
      fbStep_ff <= CNT_W'(CPID_CNT_RST);
    end
    else if (wrEn)
    begin
      if (paddr == CPID_OFS_CTRL)
      begin
        // reserved path code 3 falls back to isolated path
        cfg_ff.path <= (pwdata[1:0] == 2'h3) ? CPID_PATH_ISO : pwdata[1:0];
        cfg_ff.dir <= pwdata[CPID_CTRL_DIR_BIT];
        cfg_ff.method <= pwdata[CPID_CTRL_METH_LSB +: 2];
        cfg_ff.inhEn <= pwdata[CPID_CTRL_INHEN_BIT];
      end
      if (paddr == CPID_OFS_IRQ_MASK)
        irqMask_ff <= pwdata[3:0];
      if (paddr == CPID_OFS_FB_STEP)
        fbStep_ff <= CNT_W'(pwdata);
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cmdStep = cmdStep_ff;
  assign cmdStepValid = cmdStepValid_ff;
  assign lowFreq = lowFreq_ff;
  assign irq = irq_ff;
endmodule : cpid_decoder

// [verif/cpid_decoder_assertions.sv]
/*
  Port checker for cpid_decoder: bus answer timing and control-cycle output.
  Assumes it is bound onto cpid_decoder and is handed its parameters.
*/
`timescale 1ns/100ps
module cpid_decoder_checker
  import cpid_pkg::*;
#(
  parameter int CTRL_CYCLE_CLK = CPID_CTRL_CYCLE_CLK,
  parameter int CNT_W = 32
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CNT_W-1:0] cmdStep,
  input wire logic cmdStepValid,
  input wire logic lowFreq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [31:0] gapCnt_ff;
  // clocks since the last strobe; parked far out of range until the first one,
  // whose phase after reset is not fixed
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      gapCnt_ff <= 32'h8000_0000;
    else
      gapCnt_ff <= cmdStepValid ? 32'h0 : gapCnt_ff + 32'h1;
  end
  // bus answers: one cycle after the access phase opens, one cycle long
  a_ready_on_time: assert property ($rose(penable) && psel |=> pready) else $error("late pready");
  a_ready_single: assert property (pready |=> !pready) else $error("pready held too long");
  a_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_error_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read gave data");
  a_rdata_held: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  // step output: moves only with its strobe, strobe once per control cycle
  a_step_held: assert property ($changed(cmdStep) |-> cmdStepValid) else $error("step moved");
  a_step_period: assert property (
    gapCnt_ff < 32'h8000_0000 && (cmdStepValid || gapCnt_ff >= CTRL_CYCLE_CLK - 1)
    |-> cmdStepValid && gapCnt_ff == CTRL_CYCLE_CLK - 1) else $error("strobe period wrong");
  a_low_freq_flag: assert property ($past(cmdStepValid) |->
    lowFreq == ($signed(cmdStep) >= -1 && $signed(cmdStep) <= 1)) else $error("lowFreq wrong");
endmodule : cpid_decoder_checker

bind cpid_decoder cpid_decoder_checker #(.CTRL_CYCLE_CLK(CTRL_CYCLE_CLK), .CNT_W(CNT_W))
  cpid_decoder_checker_i (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmdStep(cmdStep), .cmdStepValid(cmdStepValid), .lowFreq(lowFreq));

// [verif/cpid_pulse_host.sv]
/*
  Host controller model driving one differential pulse/sign pair in any of the
  three command formats. Assumes the caller picks an edge spacing within rate.
*/
`timescale 1ns/100ps
module cpid_pulse_host
  import cpid_pkg::*;
(
  input wire logic core_clk,
  output logic [3:0] lines
);
  logic pulse_ff = 1'b0;
  logic sign_ff = 1'b0;
  // line driver legs {pulse +, pulse -, sign +, sign -}; minus is the complement
  assign lines = {pulse_ff, ~pulse_ff, sign_ff, ~sign_ff};
  // three formats; sign of cnt is direction, half is edge spacing in clocks
  task automatic sendTrain(input logic [1:0] meth, input int cnt, input int half);
    int k;
    for (k = 0; k < (cnt < 0 ? -cnt : cnt); k++)
    begin
      if (!meth[0])
      begin
        // forward means the pulse line leads the sign line
        if ((pulse_ff == sign_ff) ^ (cnt < 0))
          pulse_ff <= ~pulse_ff;
        else
          sign_ff <= ~sign_ff;
      end
      else
      begin
        // pulse-plus-sign sets the sign a full spacing before the pulse edge
        if (meth[1])
          sign_ff <= (cnt < 0);
        if (meth[1])
          repeat (half) @(posedge core_clk);
        if (meth[1] || cnt > 0)
          pulse_ff <= 1'b1;
        else
          sign_ff <= 1'b1;
        repeat (half) @(posedge core_clk);
        pulse_ff <= 1'b0;
        sign_ff <= meth[1] & (cnt < 0);
      end
      repeat (half) @(posedge core_clk);
    end
    // sign line back to idle low so a later format change makes no edge
    sign_ff <= 1'b0;
    repeat (half) @(posedge core_clk);
  endtask : sendTrain
endmodule : cpid_pulse_host

// [verif/command_pulse_input_decoder_tb.sv]
/*
  Self-checking bench for cpid_decoder: APB master, two host models, note queue.
  Assumes the port checker is bound onto the decoder.
*/
`timescale 1ns/100ps
module command_pulse_input_decoder_tb
  import cpid_pkg::*;
  ;
  localparam int CYC = 64;  // short control cycle keeps the run brief
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, inhibitIn = 1'b1, clearIn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, cmdStep;
  logic pready, pslverr, cmdStepValid, lowFreq, irq;
  logic [3:0] fastLn, isoLn;
  logic [64:0] notes[$];
  logic [15:0] lfsr = 16'h30D1;
  int n_errors = 0;
  int checks = 0;
  int expPos = 0;
  int stepSum = 0;
  // 100 MHz core clock
  always #5 core_clk = ~core_clk;
  cpid_decoder #(.CTRL_CYCLE_CLK(CYC)) cpid_decoder_i (.core_clk(core_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fast_pulse_pos(fastLn[3]),
    .fast_pulse_neg(fastLn[2]), .fast_sign_pos(fastLn[1]), .fast_sign_neg(fastLn[0]),
    .iso_pulse_pos(isoLn[3]), .iso_pulse_neg(isoLn[2]), .iso_sign_pos(isoLn[1]),
    .iso_sign_neg(isoLn[0]), .pulse_inhibit_in(inhibitIn), .deviation_clear_in(clearIn),
    .cmdStep(cmdStep), .cmdStepValid(cmdStepValid), .lowFreq(lowFreq), .irq(irq));
  cpid_pulse_host hostFast (.core_clk(core_clk), .lines(fastLn));
  cpid_pulse_host hostIso (.core_clk(core_clk), .lines(isoLn));
  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nextRand
  task automatic clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : clk
  // compare an answer; x or z never counts as a match
  task automatic cmpBus(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpBus
  task automatic cmpIrq(input logic exp);
    cmpBus({32'h0, irq}, {32'h0, exp});
  endtask : cmpIrq
  task automatic cmpStep(input logic [31:0] got, input logic [31:0] exp);
    cmpBus({1'b0, got}, {1'b0, exp});
  endtask : cmpStep
  // one APB transfer; the expected answer is queued before the request goes out
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic er);
    notes.push_back({wr ? 32'h0 : m, er, d});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    clk(1);
    penable <= 1'b1;
    clk(1);
    // hold the request until pready is seen; only the watchdog ends a hang
    while (!pready)
      clk(1);
    psel <= 1'b0;
    penable <= 1'b0;
    clk(1);
  endtask : apb
  // bus watcher: each answer retires the oldest note, data under its mask
  always @(posedge core_clk)
  begin
    logic [64:0] nt;
    if (pready)
    begin
      nt = notes.pop_front();
      cmpBus({pslverr, prdata & nt[64:33]}, {nt[32], nt[31:0] & nt[64:33]});
    end
  end
  // step watcher: the control-cycle counts must add up to the commanded total
  always @(posedge core_clk)
  begin
    if (cmdStepValid)
      stepSum <= stepSum + int'($signed(cmdStep));
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // main sequence
  initial
  begin
    int path;
    int meth;
    int dir;
    int cnt;
    clk(10);
    arst_n <= 1'b1;
    clk(1);
    apb(1'b0, CPID_OFS_CTRL, CPID_CTRL_RST, '1, 1'b0);
    apb(1'b0, CPID_OFS_IRQ_MASK, 32'h0, '1, 1'b0);
    apb(1'b0, 8'h40, 32'h0, '1, 1'b1);
    apb(1'b1, CPID_OFS_CMD_POS, 32'h5A, 32'h0, 1'b1);
    $display("register access test done");
    inhibitIn <= 1'b0;
    clk(10);
    hostIso.sendTrain(2'h0, 8, 110);
    clk(200);
    apb(1'b0, CPID_OFS_CMD_POS, 32'h0, '1, 1'b0);
    apb(1'b0, CPID_OFS_IRQ_STAT, 32'h4, 32'h4, 1'b0);
    apb(1'b1, CPID_OFS_IRQ_MASK, 32'hC, 32'h0, 1'b0);
    clk(2);
    cmpIrq(1'b1);
    apb(1'b1, CPID_OFS_IRQ_STAT, 32'h4, 32'h0, 1'b0);
    clk(2);
    cmpIrq(1'b0);
    inhibitIn <= 1'b1;
    $display("inhibit and interrupt test done");
    // every path, method and direction with random counts
    for (path = 0; path < 3; path++)
      for (meth = 0; meth < 4; meth++)
        for (dir = 0; dir < 2; dir++)
        begin
          lfsr = nextRand(lfsr);
          cnt = (int'(lfsr[2:0]) + 1) * (meth[0] ? 1 : 4) * (lfsr[3] ? -1 : 1);
          apb(1'b1, CPID_OFS_CTRL, 32'(path + 4 * dir + 8 * meth), 32'h0, 1'b0);
          // edge spacing keeps each path within its rate limit
          if (path == 1)
            hostFast.sendTrain(meth[1:0], cnt, 13);
          else
            hostIso.sendTrain(meth[1:0], cnt, path == 2 ? 210 : 110);
          expPos += dir ? -cnt : cnt;
          clk(150);
          apb(1'b0, CPID_OFS_CMD_POS, 32'(expPos), '1, 1'b0);
        end
    $display("pulse format test done");
    clk(3 * CYC);
    cmpStep(32'(stepSum), 32'(expPos));
    cmpBus({32'h0, lowFreq}, 33'h1);
    apb(1'b0, CPID_OFS_DEV_CNT, 32'(expPos), '1, 1'b0);
    clearIn <= 1'b1;
    apb(1'b1, CPID_OFS_IRQ_MASK, 32'h8, 32'h0, 1'b0);
    clk(4);
    cmpIrq(1'b1);
    apb(1'b0, CPID_OFS_DEV_CNT, 32'h0, '1, 1'b0);
    clearIn <= 1'b0;
    clk(5);
    apb(1'b1, CPID_OFS_IRQ_STAT, 32'h8, 32'h0, 1'b0);
    clk(2);
    cmpIrq(1'b0);
    $display("deviation clear test done");
    arst_n <= 1'b0;
    clk(3);
    arst_n <= 1'b1;
    clk(1);
    apb(1'b0, CPID_OFS_CMD_POS, CPID_CNT_RST, '1, 1'b0);
    apb(1'b0, CPID_OFS_CTRL, CPID_CTRL_RST, '1, 1'b0);
    $display("second reset test done");
    end_sim();
  end
  // watchdog: the longest random trains need under 80k clocks, so 90k means a hang
  initial
  begin
    clk(90000);
    n_errors++;
    end_sim();
  end
endmodule : command_pulse_input_decoder_tb
